// ### sim/itr_neighbour.sv
// Neighbouring modules and backplane lines seen by the trigger router
`timescale 1ns/1ps
module itr_neighbour (
    // Shared sample clock
    input wire logic sys_clk,
    // Device drivers
    input wire logic ret_o,
    input wire logic ret_oe,
    input wire logic [7:0] bp_o,
    input wire logic [7:0] bp_oe,
    // Lines into the device
    output logic ext_trig,
    output logic chain_line,
    output logic ret_line,
    output logic [7:0] bp_line
);
    logic drv_ret = 1'b0;
    logic [7:0] drv_bp = 8'h00;

    initial begin
        ext_trig = 1'b0;
        chain_line = 1'b0;
    end

    // ==========================================================
    // Wired-OR lines, idle low
    assign ret_line = drv_ret | (ret_oe & ret_o);
    assign bp_line = drv_bp | (bp_oe & bp_o);

    // Three-sample pulse on one source: 1 ext, 2 chain, 3 return, 4..11 backplane
    task automatic pulse(input logic [3:0] code);
        logic [7:0] onehot;
        onehot = (code >= 4'h4 && code <= 4'hB) ? (8'h01 << (code - 4'h4)) : 8'h00;
        @(posedge sys_clk);
        ext_trig <= (code == 4'h1);
        chain_line <= (code == 4'h2);
        drv_ret <= (code == 4'h3);
        drv_bp <= onehot;
        repeat (3) @(posedge sys_clk);
        ext_trig <= 1'b0;
        chain_line <= 1'b0;
        drv_ret <= 1'b0;
        drv_bp <= 8'h00;
    endtask
endmodule // itr_neighbour

// ### sim/itr_router_tb.sv
// Self-checking bench for the intermodule trigger router
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin mismatches++; \
    $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module itr_router_tb;
    import itr_pkg::*;
    // Timer period used in sim; long enough to load the trace before the first start
    localparam int TB_PERIOD = 100;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_dat_o, q;
    logic wb_ack_o, ext_trig, chain_in, ret_i, chain_out, ret_o, ret_oe;
    logic [7:0] bp_i, bp_o, bp_oe;
    logic [11:0] dac_data;
    logic sync_out, position_out, start_trig, advance_trig;
    logic [15:0] words [4] = '{16'h1100, 16'h2900, 16'h8300, 16'h3A00};
    int mismatches = 0;
    int cmp_count = 0;
    int starts = 0;
    int advs = 0;
    int s0, n;

    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (start_trig === 1'b1) starts++;
        if (advance_trig === 1'b1) advs++;
    end

    itr_router #(.AW(12), .TIMER_RST(32'(TB_PERIOD))) itr_router_inst (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_trig_in(ext_trig),
        .chain_in(chain_in), .return_chain_line_i(ret_i), .bp_trig_i(bp_i),
        .chain_out(chain_out), .return_chain_line_o(ret_o), .return_chain_line_oe(ret_oe),
        .bp_trig_o(bp_o), .bp_trig_oe(bp_oe), .dac_data(dac_data), .sync_out(sync_out),
        .position_out(position_out), .start_trig(start_trig), .advance_trig(advance_trig));
    itr_neighbour itr_neighbour_inst (
        .sys_clk(sys_clk), .ret_o(ret_o), .ret_oe(ret_oe), .bp_o(bp_o), .bp_oe(bp_oe),
        .ext_trig(ext_trig), .chain_line(chain_in), .ret_line(ret_i), .bp_line(bp_i));

    // ==========================================================
    // Bus access and closing report
    task summarize;
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] d);
        int k;
        k = 0;
        wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= we; wb_adr <= adr; wb_dat <= d;
        do begin @(posedge sys_clk); k++; end while (wb_ack_o !== 1'b1 && k < 20);
        if (wb_ack_o !== 1'b1) begin
            mismatches++;
            $display("[ERR] ack expected 1 seen %b", wb_ack_o);
            summarize();
        end
        q = wb_dat_o;
        wb_cyc <= 1'b0; wb_stb <= 1'b0; wb_we <= 1'b0;
        @(posedge sys_clk);
    endtask

    // One soft-started run: 4 points, dwell 2, burst 2
    task automatic run_check(input logic [1:0] os, input logic ms);
        logic bitv, outv, syncv, ret, bpen;
        int i;
        ret = (os == OUT_LCOM);
        bpen = (os == OUT_BCOM);
        xfer(1, ADR_CTRL, 32'h340DC | (32'(os) << 8) | (32'(ms) << 10) | (32'(ms) << 11)
            | (32'(ret) << 12) | (32'(bpen) << 13));
        xfer(1, ADR_SOFT_TRIG, 32'h1);
        n = 0;
        while (dac_data === DAC_MID && n < 20) begin @(posedge sys_clk); n++; end
        if (n == 20) begin
            mismatches++;
            $display("[ERR] run start expected 1 seen 0");
            summarize();
        end
        for (int k = 0; k < 16; k++) begin
            i = k % 4;
            bitv = ms ? (i == 3) : words[i][13];
            outv = (os == OUT_BIT) ? bitv : (os == OUT_LCOM) ? (bitv && ((k / 4) % 2 == 1))
                : (bitv && k >= 12);
            syncv = ms ? words[i][12] : (i == 1 || i == 3);
            `CHK("dac", words[i][11:0], dac_data)
            `CHK("position", words[i][13], position_out)
            if (ms || k > 0) `CHK("sync", syncv, sync_out)
            `CHK("chain", outv, chain_out)
            `CHK("ret", ret && outv, ret_o)
            `CHK("ret_oe", ret && outv, ret_oe)
            `CHK("bp", (bpen && outv) ? 8'h20 : 8'h00, bp_o)
            `CHK("bp_oe", (bpen && outv) ? 8'h20 : 8'h00, bp_oe)
            @(posedge sys_clk);
        end
        `CHK("idle dac", DAC_MID, dac_data)
        xfer(0, ADR_STATUS, 32'h0);
        `CHK("running", 1'b0, q[0])
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        `CHK("reset ret_oe", 1'b0, ret_oe)
        `CHK("reset bp_oe", 8'h00, bp_oe)
        `CHK("reset dac", DAC_MID, dac_data)
        s0 = starts;
        xfer(0, ADR_CTRL, 32'h0);
        `CHK("ctrl", 32'h0, q)
        xfer(0, ADR_TIMER, 32'h0);
        `CHK("timer", 32'(TB_PERIOD), q)
        xfer(0, ADR_TRACE_LEN, 32'h0);
        `CHK("trace_len", 32'(TRACE_LEN_RST), q)
        xfer(0, ADR_DWELL, 32'h0);
        `CHK("dwell", 32'(DWELL_RST), q)
        xfer(0, ADR_BURST, 32'h0);
        `CHK("burst", 32'(BURST_RST), q)
        xfer(0, 8'h30, 32'h0);
        `CHK("unmapped", 32'h0, q)
        // Trace loaded before the first timer start, so playback never reads empty memory
        xfer(1, ADR_TRACE_LEN, 32'h4);
        xfer(1, ADR_MEM_ADDR, 32'h0);
        for (int k = 0; k < 4; k++) xfer(1, ADR_MEM_DATA, {16'h0, words[k]});
        xfer(1, ADR_MEM_ADDR, 32'h2);
        xfer(0, ADR_MEM_DATA, 32'h0);
        `CHK("mem", {16'h0, words[2]}, q)
        repeat (2 * TB_PERIOD) @(posedge sys_clk);
        `CHK("timer start", 1'b1, starts > s0)
        xfer(1, ADR_CTRL, 32'hDD);
        n = 0;
        do begin xfer(0, ADR_STATUS, 32'h0); n++; end while (q[0] !== 1'b0 && n < 3000);
        `CHK("idle", 1'b0, q[0])
        xfer(1, ADR_DWELL, 32'h2);
        xfer(1, ADR_BURST, 32'h2);
        for (int os = 0; os < 3; os++)
            for (int ms = 0; ms < 2; ms++) run_check(2'(os), 1'(ms));
        xfer(1, ADR_CTRL, 32'h3DD);
        n = 0;
        repeat (10 * TB_PERIOD) begin @(posedge sys_clk); if (chain_out === 1'b1) n++; end
        `CHK("timer pulses", 10, n)
        xfer(1, ADR_DWELL, 32'h1);
        xfer(1, ADR_BURST, 32'h1);
        for (int c = 1; c < 12; c++) begin
            xfer(1, ADR_CTRL, 32'(c) | 32'hD0);
            s0 = starts;
            itr_neighbour_inst.pulse(4'(c));
            repeat (10) @(posedge sys_clk);
            `CHK("start src", 1, starts - s0)
            xfer(1, ADR_CTRL, 32'hC | (32'(c) << 4));
            s0 = advs;
            itr_neighbour_inst.pulse(4'(c));
            repeat (10) @(posedge sys_clk);
            `CHK("adv src", (c < 4) ? 1 : 0, advs - s0)
        end
        summarize();
    end
endmodule // itr_router_tb

// ### src/itr_pkg.sv
// Constants and types shared by the intermodule trigger router
package itr_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_TIMER = 8'h04;
    localparam logic [7:0] ADR_TRACE_LEN = 8'h08;
    localparam logic [7:0] ADR_DWELL = 8'h0C;
    localparam logic [7:0] ADR_BURST = 8'h10;
    localparam logic [7:0] ADR_MEM_ADDR = 8'h14;
    localparam logic [7:0] ADR_MEM_DATA = 8'h18;
    localparam logic [7:0] ADR_SOFT_TRIG = 8'h1C;
    localparam logic [7:0] ADR_STATUS = 8'h20;
    localparam logic [7:0] ADR_COUNTS = 8'h24;

    // ==========================================================
    // Control register field positions
    localparam int CTL_START_LSB = 0;
    localparam int CTL_ADV_LSB = 4;
    localparam int CTL_OUT_LSB = 8;
    localparam int CTL_MARK_SEL = 10;
    localparam int CTL_SYNC_MODE = 11;
    localparam int CTL_RET_EN = 12;
    localparam int CTL_BP_EN = 13;
    localparam int CTL_BP_LINE_LSB = 14;
    localparam int CTL_TMARK_EN = 17;

    // Trace word layout
    localparam int WORD_SYNC_BIT = 12;
    localparam int WORD_POS_BIT = 13;
    localparam int WORD_TRIG_BIT = 14;
    localparam int WORD_INTENSITY_BIT = 15;
    localparam logic [11:0] DAC_MID = 12'h800;

    // ==========================================================
    // Input trigger source codes
    localparam logic [3:0] SRC_TIMER = 4'h0;
    localparam logic [3:0] SRC_EXT = 4'h1;
    localparam logic [3:0] SRC_CHAIN = 4'h2;
    localparam logic [3:0] SRC_RETURN = 4'h3;
    localparam logic [3:0] SRC_BP0 = 4'h4;
    localparam logic [3:0] SRC_BP7 = 4'hB;
    localparam logic [3:0] SRC_SOFT = 4'hC;

    // Output trigger source codes
    localparam logic [1:0] OUT_BIT = 2'h0;
    localparam logic [1:0] OUT_LCOM = 2'h1;
    localparam logic [1:0] OUT_BCOM = 2'h2;
    localparam logic [1:0] OUT_TIMER = 2'h3;

    // ==========================================================
    // Reset values and timing
    localparam int CLK_MHZ = 100;
    localparam int TIMER_DEFAULT_US = 1000;
    localparam int TIMER_RST_CYCLES = TIMER_DEFAULT_US * CLK_MHZ;
    localparam logic [15:0] TRACE_LEN_RST = 16'h1000;
    localparam logic [15:0] DWELL_RST = 16'h0001;
    localparam logic [15:0] BURST_RST = 16'h0001;

    typedef enum logic [0:0] {
        PLAY_IDLE = 1'b0,
        PLAY_RUN = 1'b1
    } itr_play_t;

endpackage

// ### src/itr_router.sv
// Intermodule trigger router with marker qualification and Wishbone registers
// Operation
// - Input selectors: timer, ext, chains, backplane, software
// - Output trigger always drives forward chain
// - Optional return chain and one backplane line
// - Return chain is wired-OR, drive only high
// - Address advances once per sample clock
// - Trace word: 12 DAC, 4 marker bits
// - Sync output: trace sync bit or zero-crossing style
// - Position marker drives output, qualifies trigger
// - Trigger marker per trace, at last point
// - Intensity marker bit is ignored
// - Marker select picks position or trigger marker
// - Loop counter repeats each trace dwell times
// - Loop-qualified marker is marker AND loop-complete
// - Burst counter repeats trace per trigger count
// - Burst-qualified marker needs loop and burst complete
// - Internal timer is an output trigger candidate
// - Output source picks bit, lcom, bcom, timer
// - Two selectors: start trigger and advance trigger
// - Backplane lines never feed advance trigger
// - Previous module, front panel, timer feed selectors
//
// Register access over Wishbone and the address map were left to the implementer.
`timescale 1ns/1ps
module itr_router
    import itr_pkg::*;
#(
    parameter int AW = 12,
    parameter logic [31:0] TIMER_RST = 32'(TIMER_RST_CYCLES)
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Trigger pins in
    input wire logic ext_trig_in,
    input wire logic chain_in,
    input wire logic return_chain_line_i,
    input wire logic [7:0] bp_trig_i,
    // Trigger pins out
    output logic chain_out,
    output logic return_chain_line_o,
    output logic return_chain_line_oe,
    output logic [7:0] bp_trig_o,
    output logic [7:0] bp_trig_oe,
    // Waveform side
    output logic [11:0] dac_data,
    output logic sync_out,
    output logic position_out,
    output logic start_trig,
    output logic advance_trig
);

    // ==========================================================
    // State
    typedef struct packed {
        itr_play_t play;
        logic [3:0] start_src;
        logic [3:0] adv_src;
        logic [1:0] out_src;
        logic mark_sel;
        logic sync_mode;
        logic ret_en;
        logic bp_en;
        logic tmark_en;
        logic [2:0] bp_line;
        logic [31:0] period;
        logic [31:0] tcnt;
        logic tick;
        logic [15:0] trace_len;
        logic [15:0] dwell;
        logic [15:0] bcount;
        logic [15:0] loop;
        logic [15:0] burst;
        logic [AW-1:0] addr;
        logic [AW-1:0] mem_addr;
        logic [10:0] pin1;
        logic [10:0] pin2;
        logic [10:0] pin3;
        logic sw_start;
        logic sw_adv;
        logic [11:0] prev_dac;
        logic [11:0] dac;
        logic sync_out;
        logic pos_out;
        logic chain_out;
        logic ret_drv;
        logic [7:0] bp_drv;
        logic start_trig;
        logic adv_trig;
        logic ack;
        logic [31:0] dat;
    } itr_state_t;

    itr_state_t st;
    itr_state_t next_st;
    logic [15:0] trace_mem [0:(1<<AW)-1];
    logic [15:0] word;
    logic [10:0] pin_edge;
    logic [12:0] ev_start;
    logic [12:0] ev_adv;
    logic start_ev;
    logic adv_ev;
    logic last_pt;
    logic lcomp;
    logic bcomp;
    logic bit_mark;
    logic out_trig;
    logic bus_req;
    logic bus_wr;
    logic mem_we;
    logic [31:0] ctrl_word;
    logic [31:0] wval;

    // ==========================================================
    // Helpers
    function automatic logic pick_src(logic [3:0] sel, logic [12:0] ev, logic allow_bp);
        logic hit;
        hit = 1'b0;
        if (sel <= SRC_SOFT) begin
            hit = ev[sel];
        end
        if (!allow_bp && sel >= SRC_BP0 && sel <= SRC_BP7) begin
            hit = 1'b0;
        end
        return hit;
    endfunction

    function automatic logic is_last(logic [15:0] cnt, logic [15:0] lim);
        return (lim == 16'h0000) || (cnt == lim - 16'h0001);
    endfunction

    function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ==========================================================
    // Combinational next state
    always_comb begin
        next_st = st;
        // Trace read, same cycle as the flags below
        word = trace_mem[st.addr];
        // Pin synchronisers and rising edges
        next_st.pin1 = {bp_trig_i, return_chain_line_i, chain_in, ext_trig_in};
        next_st.pin2 = st.pin1;
        next_st.pin3 = st.pin2;
        pin_edge = st.pin2 & ~st.pin3;
        ev_start = {st.sw_start, pin_edge, st.tick};
        ev_adv = {st.sw_adv, pin_edge, st.tick};
        start_ev = pick_src(st.start_src, ev_start, 1'b1);
        adv_ev = pick_src(st.adv_src, ev_adv, 1'b0);
        next_st.start_trig = start_ev;
        next_st.adv_trig = adv_ev;
        // Internal trigger timer
        if (st.period == 32'h0 || st.tcnt >= st.period - 32'h1) begin
            next_st.tcnt = 32'h0;
            next_st.tick = 1'b1;
        end else begin
            next_st.tcnt = st.tcnt + 32'h1;
            next_st.tick = 1'b0;
        end
        // Playback flags
        last_pt = is_last(16'(st.addr), st.trace_len);
        lcomp = is_last(st.loop, st.dwell);
        bcomp = is_last(st.burst, st.bcount);
        // Playback sequencing
        case (st.play)
            PLAY_IDLE: begin
                if (start_ev) begin
                    next_st.play = PLAY_RUN;
                    next_st.addr = '0;
                    next_st.loop = 16'h0000;
                    next_st.burst = 16'h0000;
                end
            end
            PLAY_RUN: begin
                next_st.addr = st.addr + 1'b1;
                if (adv_ev && st.dwell != 16'h0000) begin
                    next_st.loop = st.dwell - 16'h0001;
                end
                if (last_pt) begin
                    next_st.addr = '0;
                    if (!lcomp) begin
                        next_st.loop = st.loop + 16'h0001;
                    end else begin
                        next_st.loop = 16'h0000;
                        if (!bcomp) begin
                            next_st.burst = st.burst + 16'h0001;
                        end else begin
                            next_st.burst = 16'h0000;
                            next_st.play = PLAY_IDLE;
                        end
                    end
                end
            end
            default: begin
                next_st.play = PLAY_IDLE;
            end
        endcase
        // Markers; intensity bit is never read
        bit_mark = 1'b0;
        if (st.play == PLAY_RUN) begin
            bit_mark = st.mark_sel ? (st.tmark_en & last_pt)
                                   : word[WORD_POS_BIT];
        end
        case (st.out_src)
            OUT_BIT: out_trig = bit_mark;
            OUT_LCOM: out_trig = bit_mark & lcomp;
            OUT_BCOM: out_trig = bit_mark & lcomp & bcomp;
            default: out_trig = st.tick;
        endcase
        next_st.chain_out = out_trig;
        next_st.ret_drv = st.ret_en & out_trig;
        next_st.bp_drv = (st.bp_en & out_trig) ? (8'h01 << st.bp_line) : 8'h00;
        // Waveform outputs
        if (st.play == PLAY_RUN) begin
            next_st.dac = word[11:0];
            next_st.prev_dac = word[11:0];
            next_st.pos_out = word[WORD_POS_BIT];
            if (st.sync_mode) begin
                next_st.sync_out = word[WORD_SYNC_BIT];
            end else begin
                next_st.sync_out = (st.prev_dac < DAC_MID) && (word[11:0] >= DAC_MID);
            end
        end else begin
            next_st.dac = DAC_MID;
            next_st.prev_dac = DAC_MID;
            next_st.pos_out = 1'b0;
            next_st.sync_out = 1'b0;
        end
        // Wishbone slave: ack one cycle after request, write at ack edge
        bus_req = wb_cyc_i & wb_stb_i;
        bus_wr = bus_req & wb_we_i & st.ack;
        next_st.ack = bus_req & ~st.ack;
        next_st.sw_start = 1'b0;
        next_st.sw_adv = 1'b0;
        mem_we = 1'b0;
        ctrl_word = 32'h0;
        ctrl_word[CTL_START_LSB +: 4] = st.start_src;
        ctrl_word[CTL_ADV_LSB +: 4] = st.adv_src;
        ctrl_word[CTL_OUT_LSB +: 2] = st.out_src;
        ctrl_word[CTL_MARK_SEL] = st.mark_sel;
        ctrl_word[CTL_SYNC_MODE] = st.sync_mode;
        ctrl_word[CTL_RET_EN] = st.ret_en;
        ctrl_word[CTL_BP_EN] = st.bp_en;
        ctrl_word[CTL_BP_LINE_LSB +: 3] = st.bp_line;
        ctrl_word[CTL_TMARK_EN] = st.tmark_en;
        wval = 32'h0;
        next_st.dat = 32'h0;
        if (bus_req && !st.ack) begin
            case (wb_adr_i)
                ADR_CTRL: next_st.dat = ctrl_word;
                ADR_TIMER: next_st.dat = st.period;
                ADR_TRACE_LEN: next_st.dat = {16'h0000, st.trace_len};
                ADR_DWELL: next_st.dat = {16'h0000, st.dwell};
                ADR_BURST: next_st.dat = {16'h0000, st.bcount};
                ADR_MEM_ADDR: next_st.dat = 32'(st.mem_addr);
                ADR_MEM_DATA: next_st.dat = {16'h0000, trace_mem[st.mem_addr]};
                ADR_STATUS: next_st.dat = {31'h0, st.play == PLAY_RUN};
                ADR_COUNTS: next_st.dat = {st.burst, st.loop};
                default: next_st.dat = 32'h0;
            endcase
        end
        if (bus_wr) begin
            case (wb_adr_i)
                ADR_CTRL: begin
                    wval = merge(ctrl_word, wb_dat_i, wb_sel_i);
                    next_st.start_src = wval[CTL_START_LSB +: 4];
                    next_st.adv_src = wval[CTL_ADV_LSB +: 4];
                    next_st.out_src = wval[CTL_OUT_LSB +: 2];
                    next_st.mark_sel = wval[CTL_MARK_SEL];
                    next_st.sync_mode = wval[CTL_SYNC_MODE];
                    next_st.ret_en = wval[CTL_RET_EN];
                    next_st.bp_en = wval[CTL_BP_EN];
                    next_st.bp_line = wval[CTL_BP_LINE_LSB +: 3];
                    next_st.tmark_en = wval[CTL_TMARK_EN];
                end
                ADR_TIMER: next_st.period = merge(st.period, wb_dat_i, wb_sel_i);
                ADR_TRACE_LEN: begin
                    wval = merge({16'h0000, st.trace_len}, wb_dat_i, wb_sel_i);
                    next_st.trace_len = wval[15:0];
                end
                ADR_DWELL: begin
                    wval = merge({16'h0000, st.dwell}, wb_dat_i, wb_sel_i);
                    next_st.dwell = wval[15:0];
                end
                ADR_BURST: begin
                    wval = merge({16'h0000, st.bcount}, wb_dat_i, wb_sel_i);
                    next_st.bcount = wval[15:0];
                end
                ADR_MEM_ADDR: next_st.mem_addr = wb_dat_i[AW-1:0];
                ADR_MEM_DATA: begin
                    mem_we = 1'b1;
                    next_st.mem_addr = st.mem_addr + 1'b1;
                end
                ADR_SOFT_TRIG: begin
                    next_st.sw_start = wb_dat_i[0];
                    next_st.sw_adv = wb_dat_i[1];
                end
                default: wval = 32'h0;
            endcase
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st <= '0;
            st.play <= PLAY_IDLE;
            st.start_src <= SRC_TIMER;
            st.adv_src <= SRC_TIMER;
            st.ret_en <= 1'b0;
            st.bp_en <= 1'b0;
            st.period <= TIMER_RST;
            st.trace_len <= TRACE_LEN_RST;
            st.dwell <= DWELL_RST;
            st.bcount <= BURST_RST;
            st.dac <= DAC_MID;
            st.prev_dac <= DAC_MID;
        end else begin
            st <= next_st;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (mem_we) begin
            trace_mem[st.mem_addr] <= wb_dat_i[15:0];
        end
    end

    assign wb_dat_o = st.dat;
    assign wb_ack_o = st.ack;
    assign chain_out = st.chain_out;
    assign return_chain_line_o = st.ret_drv;
    assign return_chain_line_oe = st.ret_drv;
    assign bp_trig_o = st.bp_drv;
    assign bp_trig_oe = st.bp_drv;
    assign dac_data = st.dac;
    assign sync_out = st.sync_out;
    assign position_out = st.pos_out;
    assign start_trig = st.start_trig;
    assign advance_trig = st.adv_trig;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_ret_follows_chain: assert property (return_chain_line_oe |-> chain_out)
        else $error("return chain driven without output trigger");
    a_ret_gated: assert property (!st.ret_en |=> !return_chain_line_oe)
        else $error("return chain driven while disabled");
    a_bp_one_line: assert property (bp_trig_oe != 8'h00 |->
        bp_trig_oe == (8'h01 << $past(st.bp_line)) && $past(st.bp_en))
        else $error("backplane driver on wrong or disabled line");
    a_adv_no_bp: assert property (st.adv_src >= SRC_BP0 && st.adv_src <= SRC_BP7
        |=> !advance_trig)
        else $error("advance trigger taken from backplane line");
    a_reset_defaults: assert property (disable iff (1'b0) sys_rst |=>
        st.start_src == SRC_TIMER && !return_chain_line_oe && bp_trig_oe == 8'h00)
        else $error("reset defaults wrong");
    a_lcom_qualified: assert property (st.out_src == OUT_LCOM && st.play == PLAY_RUN
        && !lcomp |=> !chain_out)
        else $error("loop-qualified trigger outside final loop");
    a_bcom_qualified: assert property (st.out_src == OUT_BCOM && !(lcomp && bcomp)
        |=> !chain_out)
        else $error("burst-qualified trigger outside final burst");
    a_tmark_last: assert property (st.out_src == OUT_BIT && st.mark_sel
        && st.play == PLAY_RUN |=> chain_out == $past(st.tmark_en && last_pt))
        else $error("trigger marker not at final point");
    a_timer_out: assert property (st.out_src == OUT_TIMER |=> chain_out == $past(st.tick))
        else $error("timer not routed to output trigger");
    a_pos_out: assert property (st.play == PLAY_RUN |=> position_out == $past(word[13]))
        else $error("position output mismatch");
    a_addr_step: assert property (st.play == PLAY_RUN && !last_pt |=>
        st.addr == $past(st.addr) + 1'b1)
        else $error("address did not advance by one");
    a_ack_one: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    c_run_start: cover property (st.play == PLAY_IDLE ##1 st.play == PLAY_RUN);
    c_bcom_fire: cover property (st.out_src == OUT_BCOM && chain_out);
    c_ret_drive: cover property (return_chain_line_oe);
    c_bp_drive: cover property (bp_trig_oe != 8'h00);

endmodule // itr_router
